// *** bench/sls_host_model.sv ***
/*
 * sls_host_model: far side of the sequencer: a host running classic
 * Wishbone cycles and trigger-pin pulses, plus the stored list.
 * Assumes the sequencer acks every request and reads the store combinationally.
 */
`default_nettype none
module sls_host_model (
	// clock
	input wire logic i_clk,
	// wishbone master side
	output logic o_wb_cyc,
	output logic o_wb_stb,
	output logic o_wb_we,
	output logic [7:0] o_wb_adr,
	output logic [3:0] o_wb_sel,
	output logic [31:0] o_wb_dat,
	input wire logic [31:0] i_wb_dat,
	input wire logic i_wb_ack,
	// trigger pin and stored list
	output logic o_trigger_input_pin,
	input wire logic [9:0] i_nvm_addr,
	output logic [71:0] o_nvm_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus, trigger pin resting high
	initial
	begin
		o_wb_cyc = 1'b0;
		o_wb_stb = 1'b0;
		o_wb_we = 1'b0;
		o_wb_adr = 8'h00;
		o_wb_sel = 4'h0;
		o_wb_dat = 32'h0000_0000;
		o_trigger_input_pin = 1'b1;
	end

	// stored point n: frequency 0x2000 + n, level n
	assign o_nvm_data = {56'h00_0000_0000_2000 + {46'h0, i_nvm_addr}, 6'h00, i_nvm_addr};

	// one classic cycle; request held until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge i_clk);
		o_wb_cyc <= 1'b1;
		o_wb_stb <= 1'b1;
		o_wb_we <= we;
		o_wb_adr <= adr;
		o_wb_sel <= 4'hF;
		o_wb_dat <= d;
		do
			@(posedge i_clk);
		while (i_wb_ack !== 1'b1);
		q = i_wb_dat;
		o_wb_cyc <= 1'b0;
		o_wb_stb <= 1'b0;
		o_wb_we <= 1'b0;
		o_wb_sel <= 4'h0;
	endtask : wb_xfer

	// falling edge on the pin; each level held 4 cycles so the synchroniser sees it
	task automatic pulse_trigger();
		@(posedge i_clk);
		o_trigger_input_pin <= 1'b0;
		repeat (4) @(posedge i_clk);
		o_trigger_input_pin <= 1'b1;
		repeat (4) @(posedge i_clk);
	endtask : pulse_trigger
endmodule : sls_host_model
`default_nettype wire

// *** bench/tb_top.sv ***
/*
 * tb_top: self-checking bench for the sweep/list sequencer.
 * Assumes the host model for bus cycles, trigger pulses and the stored list.
 */
`default_nettype none
module tb_top
	import sls_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	// shortened settle and dwell counts keep the run brief
	localparam int FS = 20;
	localparam int LS = 30;
	localparam int DC = 10;
	localparam int DW = 20;
	localparam int DN = DW * DC;
	localparam logic [55:0] F0 = 56'h100;
	localparam logic [55:0] FSTEP = 56'h10;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic hard_rst_n = 1'b1;
	logic ref_det = 1'b0;
	logic cyc, stb, we, ack, busy, tout, ext, trig;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [9:0] nvm_a;
	logic [71:0] nvm_d;
	logic [55:0] freq;
	logic [15:0] lvl;
	int n_errors = 0;
	int samples_checked = 0;
	int n_tout = 0;
	int cycles = 0;
	logic tout_every = 1'b0;

	always #5 i_clk = ~i_clk;

	sls_sweep_list_sequencer #(.FREQ_SET_CYC(FS), .LVL_SET_CYC(LS), .DWELL_CYC(DC))
	u_sls_sweep_list_sequencer (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hard_rst_n(hard_rst_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_trigger_input_pin(trig), .o_trigger_output_pin(tout),
		.i_ref_detect(ref_det), .o_ref_ext_sel(ext),
		.o_nvm_addr(nvm_a), .i_nvm_data(nvm_d),
		.o_freq(freq), .o_level(lvl), .o_busy(busy)
	);

	sls_host_model u_sls_host_model (
		.i_clk(i_clk), .o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr),
		.o_wb_sel(sel), .o_wb_dat(wdat), .i_wb_dat(rdat), .i_wb_ack(ack),
		.o_trigger_input_pin(trig), .i_nvm_addr(nvm_a), .o_nvm_data(nvm_d)
	);

	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	// count trigger-output falls
	always @(negedge tout)
		n_tout++;

	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [55:0] exp, input logic [55:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// bus helpers; a 56-bit word goes as two halves
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_sls_host_model.wb_xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_sls_host_model.wb_xfer(1'b0, a, 32'h0000_0000, q);
		check(what, e, q);
	endtask : rdchk

	task automatic rdbit(input string what, input int b, input logic e);
		logic [31:0] q;
		u_sls_host_model.wb_xfer(1'b0, ADR_STATUS, 32'h0000_0000, q);
		check(what, e, q[b]);
	endtask : rdbit

	task automatic wrf(input logic [1:0] idx, input logic [55:0] v);
		wr(ADR_FREQ_BASE + {3'h0, idx, 3'h0}, v[31:0]);
		wr(ADR_FREQ_BASE + {3'h0, idx, 3'h4}, {8'h00, v[55:32]});
	endtask : wrf

	// start 0x100, stop 0x130, step 0x10, then sweep/list mode
	task automatic setup(input logic [31:0] cfg, input logic [31:0] cnt);
		wrf(FI_START, F0);
		wrf(FI_STOP, F0 + 3 * FSTEP);
		wrf(FI_STEP, FSTEP);
		wr(ADR_DWELL, 32'(DW));
		wr(ADR_CYCLES, cnt);
		wr(ADR_CFG, cfg);
		wr(ADR_CTRL, 32'h0000_0001);
	endtask : setup

	// must be entered at a clock edge so both counts are in whole cycles
	task automatic wait_point(output logic [55:0] f, output int hi, output int gap);
		gap = 0;
		hi = 0;
		while (busy !== 1'b1)
		begin
			@(posedge i_clk);
			gap++;
		end
		while (busy !== 1'b0)
		begin
			@(posedge i_clk);
			hi++;
		end
		f = freq;
	endtask : wait_point

	// point i is base + stp * nibble i of code; first point's timing is not judged
	task automatic run_expect(input logic [55:0] base, input logic [55:0] stp,
		input logic [31:0] code, input int n, input int settle);
		logic [55:0] f;
		int hi;
		int gap;
		for (int i = 0; i < n; i++)
		begin
			wait_point(f, hi, gap);
			check("point", base + stp * code[4*i +: 4], f);
			if (i > 0)
			begin
				check("settle", settle, hi);
				check("dwell", DN, gap);
			end
			if (tout_every)
				check("trig out", 1'b0, tout);
		end
	endtask : run_expect

	task automatic expect_quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n)
		begin
			@(posedge i_clk);
			if (busy === 1'b1)
				seen = 1'b1;
		end
		check("quiet", 1'b0, seen);
	endtask : expect_quiet

	task automatic t_reset();
		check("freq", TONE_RST, freq);
		check("trig out", 1'b1, tout);
		check("ext ref", 1'b0, ext);
		rdchk("cfg", ADR_CFG, {24'h0, CFG_RST});
		rdchk("dwell", ADR_DWELL, DWELL_RST);
		rdchk("unmapped", 8'hFC, 32'h0000_0000);
	endtask : t_reset

	// retune in single mode; triggers and tone writes refused outside their mode
	task automatic t_tone();
		wrf(FI_TONE, 56'h12_3456_789A_BCDE);
		repeat (3 * FS) @(posedge i_clk);
		check("tone", 56'h12_3456_789A_BCDE, freq);
		wr(ADR_CFG, 32'h0000_0011);
		u_sls_host_model.pulse_trigger();
		expect_quiet(3 * FS);
		wr(ADR_CTRL, 32'h0000_0001);
		wrf(FI_TONE, 56'h00_0000_0000_0777);
		repeat (3 * FS) @(posedge i_clk);
		check("tone", 56'h12_3456_789A_BCDE, freq);
	endtask : t_tone

	task automatic t_saw();
		setup(32'h0000_0041, 32'h0000_0002);
		n_tout = 0;
		tout_every = 1'b1;
		wr(ADR_SOFT_TRIG, 32'h0000_0001);
		run_expect(F0, FSTEP, 32'h3210_3210, 8, FS);
		tout_every = 1'b0;
		expect_quiet(DN + 2 * FS);
		check("hold", F0 + 3 * FSTEP, freq);
		check("trig outs", 8, n_tout);
		rdchk("cycles", ADR_DONE, 32'h0000_0002);
	endtask : t_saw

	task automatic t_tri();
		setup(32'h0000_00C7, 32'h0000_0001);
		n_tout = 0;
		wr(ADR_SOFT_TRIG, 32'h0000_0001);
		run_expect(F0, FSTEP, 32'h0321_0123, 7, FS);
		expect_quiet(DN + 2 * FS);
		check("trig outs", 1, n_tout);
	endtask : t_tri

	// host-filled list with levels, return to first point at the end
	task automatic t_list();
		setup(32'h0000_0020, 32'h0000_0001);
		wr(ADR_POINTS, 32'h0000_0003);
		for (int i = 0; i < 3; i++)
		begin
			wr(ADR_BUF_LVL, 32'(i + 5));
			wr(ADR_BUF_LO, 32'h0000_0500 + 32'(i * 16));
			wr(ADR_BUF_HI, 32'h0000_0000);
		end
		wr(ADR_SOFT_TRIG, 32'h0000_0001);
		run_expect(56'h500, FSTEP, 32'h0000_0210, 3, FS + LS);
		run_expect(56'h500, FSTEP, 32'h0000_0000, 1, 0);
		check("level", 16'h0005, lvl);
		expect_quiet(DN);
	endtask : t_list

	task automatic t_hw();
		setup(32'h0000_0011, 32'h0000_0000);
		u_sls_host_model.pulse_trigger();
		run_expect(F0, FSTEP, 32'h0000_0010, 2, FS);
		u_sls_host_model.pulse_trigger();
		rdbit("running", 2, 1'b0);
		expect_quiet(DN + FS);
		u_sls_host_model.pulse_trigger();
		run_expect(F0, FSTEP, 32'h0000_0000, 1, 0);
		wr(ADR_CTRL, 32'h0000_0000);
		expect_quiet(DN + FS);
	endtask : t_hw

	task automatic t_step();
		setup(32'h0000_0019, 32'h0000_0000);
		u_sls_host_model.pulse_trigger();
		run_expect(F0, FSTEP, 32'h0000_0000, 1, 0);
		expect_quiet(DN + FS);
		u_sls_host_model.pulse_trigger();
		run_expect(F0 + FSTEP, FSTEP, 32'h0000_0000, 1, 0);
		wr(ADR_SOFT_TRIG, 32'h0000_0001);
		expect_quiet(DN + FS);
		rdbit("step state", 3, 1'b0);
	endtask : t_step

	// the load streams all 1024 entries, so poll the transfer flag
	task automatic t_nvm();
		logic [31:0] q;
		wr(ADR_NVM_XFER, 32'h0000_0001);
		q = 32'h0000_0020;
		while (q[5] !== 1'b0)
			u_sls_host_model.wb_xfer(1'b0, ADR_STATUS, 32'h0000_0000, q);
		rdchk("points", ADR_POINTS, 32'h0000_0400);
		wr(ADR_POINTS, 32'h0000_07D0);
		rdchk("clamp", ADR_POINTS, 32'h0000_0400);
		setup(32'h0000_0000, 32'h0000_0001);
		wr(ADR_POINTS, 32'h0000_0002);
		wr(ADR_SOFT_TRIG, 32'h0000_0001);
		run_expect(56'h2000, 56'h1, 32'h0000_0010, 2, FS + LS);
		check("level", 16'h0001, lvl);
		// let the held run finish, then walk the same two points backwards
		expect_quiet(DN);
		wr(ADR_CFG, 32'h0000_0002);
		wr(ADR_SOFT_TRIG, 32'h0000_0001);
		run_expect(56'h2000, 56'h1, 32'h0000_0001, 2, FS + LS);
	endtask : t_nvm

	task automatic t_ref();
		wr(ADR_CTRL, 32'h0000_0002);
		repeat (4) @(posedge i_clk);
		check("ext ref", 1'b0, ext);
		ref_det <= 1'b1;
		repeat (4) @(posedge i_clk);
		wr(ADR_CTRL, 32'h0000_0002);
		repeat (4) @(posedge i_clk);
		check("ext ref", 1'b1, ext);
	endtask : t_ref

	task automatic t_hard();
		wr(ADR_CFG, 32'h0000_00FF);
		wr(ADR_DWELL, 32'h0000_0007);
		hard_rst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		hard_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		rdchk("cfg", ADR_CFG, {24'h0, CFG_RST});
		rdchk("dwell", ADR_DWELL, DWELL_RST);
		rdchk("start", ADR_FREQ_BASE + 8'h08, 32'h0000_0000);
		check("freq", TONE_RST, freq);
	endtask : t_hard

	// reset for three cycles, then every scenario in turn
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		t_reset();
		t_tone();
		t_saw();
		t_tri();
		t_list();
		t_hw();
		t_step();
		t_nvm();
		t_ref();
		t_hard();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire

// *** hdl/sls_pkg.sv ***
/*
 * sls_pkg: shared constants for the sweep/list sequencer.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
 */
`default_nettype none
package sls_pkg;
	// clock and timing figures
	localparam int CLK_MHZ = 100;
	localparam int CLK_NS = 10;
	localparam int FREQ_SET_US = 250;
	localparam int LVL_SET_US = 350;
	localparam int DWELL_UNIT_US = 500;
	localparam int TRIG_LOW_NS = 1000;
	localparam int FREQ_SET_CYC_D = FREQ_SET_US * CLK_MHZ;
	localparam int LVL_SET_CYC_D = LVL_SET_US * CLK_MHZ;
	localparam int DWELL_CYC_D = DWELL_UNIT_US * CLK_MHZ;
	localparam int TRIG_LOW_CYC = TRIG_LOW_NS / CLK_NS;
	// list storage
	localparam int LIST_MAX = 1024;
	localparam int FW = 56;
	localparam int LW = 16;
	// register byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_CFG = 8'h04;
	localparam logic [7:0] ADR_FREQ_BASE = 8'h20;
	localparam logic [7:0] ADR_DWELL = 8'h40;
	localparam logic [7:0] ADR_CYCLES = 8'h44;
	localparam logic [7:0] ADR_POINTS = 8'h48;
	localparam logic [7:0] ADR_BUF_LO = 8'h4C;
	localparam logic [7:0] ADR_BUF_HI = 8'h50;
	localparam logic [7:0] ADR_BUF_LVL = 8'h54;
	localparam logic [7:0] ADR_SOFT_TRIG = 8'h58;
	localparam logic [7:0] ADR_NVM_XFER = 8'h5C;
	localparam logic [7:0] ADR_STATUS = 8'h60;
	localparam logic [7:0] ADR_DONE = 8'h64;
	// frequency word index inside the frequency block
	localparam logic [1:0] FI_TONE = 2'h0;
	localparam logic [1:0] FI_START = 2'h1;
	localparam logic [1:0] FI_STOP = 2'h2;
	localparam logic [1:0] FI_STEP = 2'h3;
	// field positions
	localparam int CTRL_MODE = 0;
	localparam int CTRL_EXTREF = 1;
	localparam int CFG_SWEEP = 0;
	localparam int CFG_REV = 1;
	localparam int CFG_TRI = 2;
	localparam int CFG_STEP = 3;
	localparam int CFG_HWTRIG = 4;
	localparam int CFG_RET = 5;
	localparam int CFG_TOUT_EN = 6;
	localparam int CFG_TOUT_LAST = 7;
	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [55:0] TONE_RST = 56'h00_0DA4_75AB_F000;
	localparam logic [31:0] DWELL_RST = 32'h0000_0002;
	localparam logic [31:0] CYCLES_RST = 32'h0000_0000;
	// sequencer states
	typedef enum logic [1:0] {SQ_IDLE, SQ_SETTLE, SQ_DWELL, SQ_STEPW} sls_state_e;
endpackage : sls_pkg
`default_nettype wire

// *** hdl/sls_sweep_list_sequencer.sv ***
/*
 * Sweep/list frequency sequencer with Wishbone registers, trigger in/out,
 * list buffer, nonvolatile list loader and external reference check.
 * Assumes a combinational-read nonvolatile store answering in the address cycle.
 */
`default_nettype none
module sls_sweep_list_sequencer
	import sls_pkg::*;
#(
	parameter int FREQ_SET_CYC = FREQ_SET_CYC_D,
	parameter int LVL_SET_CYC = LVL_SET_CYC_D,
	parameter int DWELL_CYC = DWELL_CYC_D
) (
	// clock and resets
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_hard_rst_n,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// trigger pins
	input wire logic i_trigger_input_pin,
	output logic o_trigger_output_pin,
	// reference
	input wire logic i_ref_detect,
	output logic o_ref_ext_sel,
	// nonvolatile list store
	output logic [9:0] o_nvm_addr,
	input wire logic [71:0] i_nvm_data,
	// tuned point
	output logic [55:0] o_freq,
	output logic [15:0] o_level,
	output logic o_busy
);
	localparam logic [15:0] SET_F = 16'(FREQ_SET_CYC);
	localparam logic [15:0] SET_FL = 16'(FREQ_SET_CYC + LVL_SET_CYC);
	localparam logic [15:0] DW_PRE = 16'(DWELL_CYC);
	localparam logic [10:0] PTS_MAX = 11'(LIST_MAX);

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [3:0] s,
		input logic [31:0] d);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b]) r[8*b +: 8] = d[8*b +: 8];
		return r;
	endfunction : wmerge

	// synchronisers: trigger, reference detect, hard reset
	logic t1_ff, t2_ff, t3_ff, r1_ff, r2_ff, h1_ff, h2_ff;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		// hard-reset stages rest released, else a write just after reset is wiped
		if (!i_rst_n) {t1_ff, t2_ff, t3_ff, r1_ff, r2_ff, h1_ff, h2_ff} <= 7'h03;
		else {t1_ff, t2_ff, t3_ff, r1_ff, r2_ff, h1_ff, h2_ff} <=
			{i_trigger_input_pin, t1_ff, t2_ff, i_ref_detect, r1_ff, i_hard_rst_n, h1_ff};
	end
	wire logic trg_fall = t3_ff & ~t2_ff;
	wire logic hr = ~h2_ff; // header reset line held low

	// bus decode; writes land on the edge that raises ack
	logic ack_ff;
	wire logic acc = i_wb_cyc & i_wb_stb & ~ack_ff;
	wire logic wr = acc & i_wb_we;
	wire logic fr_hit = (i_wb_adr & 8'hE0) == ADR_FREQ_BASE;
	wire logic [1:0] fk = i_wb_adr[4:3];
	wire logic soft_wr = wr && i_wb_adr == ADR_SOFT_TRIG;

	// configuration registers
	logic [1:0] ctrl_ff, nxt_ctrl;
	logic [7:0] cfg_ff, nxt_cfg;
	logic [55:0] fr_ff [0:3];
	logic [55:0] nxt_fr [0:3];
	logic [31:0] dwell_ff, nxt_dwell, cycles_ff, nxt_cycles, blo_ff, nxt_blo;
	logic [15:0] blvl_ff, nxt_blvl;
	logic [10:0] pts_ff, nxt_pts;
	logic ref_ff, nxt_ref;
	wire logic mode = ctrl_ff[CTRL_MODE];
	wire logic tone_wr = wr && fr_hit && fk == FI_TONE && !mode;
	logic xfer_ff;
	always_comb
	begin
		logic [31:0] t;
		t = 32'h0;
		nxt_ctrl = ctrl_ff;
		nxt_cfg = cfg_ff;
		nxt_fr = fr_ff;
		nxt_dwell = dwell_ff;
		nxt_cycles = cycles_ff;
		nxt_blo = blo_ff;
		nxt_blvl = blvl_ff;
		nxt_pts = pts_ff;
		nxt_ref = ref_ff;
		if (wr && fr_hit && !(fk == FI_TONE && mode))
		begin
			t = i_wb_adr[2] ? {8'h00, fr_ff[fk][55:32]} : fr_ff[fk][31:0];
			t = wmerge(t, i_wb_sel, i_wb_dat);
			if (i_wb_adr[2]) nxt_fr[fk][55:32] = t[23:0];
			else nxt_fr[fk][31:0] = t;
		end
		if (wr)
			case (i_wb_adr)
				ADR_CTRL:
				begin
					t = wmerge({30'h0, ctrl_ff}, i_wb_sel, i_wb_dat);
					nxt_ctrl = t[1:0];
					// lock externally only when a signal is present
					nxt_ref = t[CTRL_EXTREF] & r2_ff;
				end
				ADR_CFG:
				begin
					t = wmerge({24'h0, cfg_ff}, i_wb_sel, i_wb_dat);
					nxt_cfg = t[7:0];
				end
				ADR_DWELL: nxt_dwell = wmerge(dwell_ff, i_wb_sel, i_wb_dat);
				ADR_CYCLES: nxt_cycles = wmerge(cycles_ff, i_wb_sel, i_wb_dat);
				ADR_POINTS:
				begin
					t = wmerge({21'h0, pts_ff}, i_wb_sel, i_wb_dat);
					nxt_pts = (t[10:0] > PTS_MAX) ? PTS_MAX : t[10:0];
				end
				ADR_BUF_LO: nxt_blo = wmerge(blo_ff, i_wb_sel, i_wb_dat);
				ADR_BUF_LVL:
				begin
					t = wmerge({16'h0, blvl_ff}, i_wb_sel, i_wb_dat);
					nxt_blvl = t[15:0];
				end
				ADR_NVM_XFER: if (!xfer_ff) nxt_pts = PTS_MAX;
				default: ;
			endcase
		// header reset discards every user setting except the buffer low word and buffer level
		if (hr)
		begin
			nxt_ctrl = CTRL_RST;
			nxt_cfg = CFG_RST;
			nxt_fr = '{TONE_RST, 56'h0, 56'h0, 56'h0};
			nxt_dwell = DWELL_RST;
			nxt_cycles = CYCLES_RST;
			nxt_pts = 11'h000;
			nxt_ref = 1'b0;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl_ff <= CTRL_RST;
			cfg_ff <= CFG_RST;
			fr_ff <= '{TONE_RST, 56'h0, 56'h0, 56'h0};
			dwell_ff <= DWELL_RST;
			cycles_ff <= CYCLES_RST;
			blo_ff <= 32'h0;
			blvl_ff <= 16'h0;
			pts_ff <= 11'h000;
			ref_ff <= 1'b0;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			cfg_ff <= nxt_cfg;
			fr_ff <= nxt_fr;
			dwell_ff <= nxt_dwell;
			cycles_ff <= nxt_cycles;
			blo_ff <= nxt_blo;
			blvl_ff <= nxt_blvl;
			pts_ff <= nxt_pts;
			ref_ff <= nxt_ref;
		end
	end

	// list buffer: host append or stream from the stored list
	logic [71:0] mem [0:LIST_MAX-1];
	logic [10:0] wp_ff, nxt_wp, xa_ff, nxt_xa;
	logic [9:0] na_ff, nxt_na;
	logic xv_ff, nxt_xv, nxt_xfer, mwe;
	logic [9:0] mwa;
	logic [71:0] mwd;
	always_comb
	begin
		nxt_wp = wp_ff;
		nxt_xa = xa_ff;
		nxt_na = na_ff;
		nxt_xfer = xfer_ff;
		nxt_xv = xfer_ff;
		mwe = 1'b0;
		mwa = wp_ff[9:0];
		mwd = {i_wb_dat[23:0], blo_ff, blvl_ff};
		if (xfer_ff)
		begin
			nxt_na = xa_ff[9:0];
			nxt_xa = xa_ff + 11'h001;
			nxt_xfer = xa_ff != PTS_MAX - 11'h001;
		end
		if (xv_ff)
		begin
			mwe = 1'b1;
			mwa = na_ff;
			mwd = i_nvm_data;
		end
		else if (wr && i_wb_adr == ADR_BUF_HI && wp_ff < PTS_MAX)
		begin
			mwe = 1'b1;
			nxt_wp = wp_ff + 11'h001;
		end
		if (wr && i_wb_adr == ADR_POINTS) nxt_wp = 11'h000;
		if (wr && i_wb_adr == ADR_NVM_XFER && !xfer_ff)
		begin
			nxt_xfer = 1'b1;
			nxt_xa = 11'h000;
		end
		if (hr)
		begin
			nxt_wp = 11'h000;
			nxt_xfer = 1'b0;
			nxt_xv = 1'b0;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n) {wp_ff, xa_ff, na_ff, xfer_ff, xv_ff} <= 34'h0;
		else {wp_ff, xa_ff, na_ff, xfer_ff, xv_ff} <= {nxt_wp, nxt_xa, nxt_na, nxt_xfer, nxt_xv};
	end
	// storage has no reset; the point count guards stale entries
	always_ff @(posedge i_clk)
	begin
		if (mwe) mem[mwa] <= mwd;
	end

	// sequencer
	sls_state_e st_ff, nxt_st;
	logic [55:0] cur_ff, nxt_cur, f_ff, nxt_f;
	logic [15:0] l_ff, nxt_l, cnt_ff, nxt_cnt, pre_ff, nxt_pre;
	logic [9:0] idx_ff, nxt_idx;
	logic [31:0] dw_ff, nxt_dw, done_ff, nxt_done;
	logic [7:0] tc_ff, nxt_tc;
	logic ph_ff, nxt_ph, run_ff, nxt_run, sm_ff, nxt_sm;
	wire logic swp = cfg_ff[CFG_SWEEP];
	wire logic rev = cfg_ff[CFG_REV];
	wire logic tri_wave = cfg_ff[CFG_TRI];
	wire logic hwm = cfg_ff[CFG_HWTRIG];
	// forward climbs, reverse descends; the triangle's return leg flips it
	wire logic up = ~(rev ^ ph_ff);
	wire logic [56:0] cp = {1'b0, cur_ff} + {1'b0, fr_ff[FI_STEP]};
	wire logic [56:0] sp = {1'b0, fr_ff[FI_START]} + {1'b0, fr_ff[FI_STEP]};
	wire logic [10:0] ip = {1'b0, idx_ff} + 11'h001;
	wire logic at_end = swp ? (up ? cp > {1'b0, fr_ff[FI_STOP]} : {1'b0, cur_ff} < sp)
		: (up ? ip >= pts_ff : idx_ff == 10'h000);
	wire logic cyc_end = at_end && (!tri_wave || ph_ff);
	wire logic [55:0] first_f = rev ? fr_ff[FI_STOP] : fr_ff[FI_START];
	wire logic [10:0] lastp = pts_ff - 11'h001;
	wire logic [9:0] first_i = rev ? lastp[9:0] : 10'h000;
	wire logic trig = mode && (hwm ? trg_fall : soft_wr);
	wire logic [15:0] set_cyc = swp ? SET_F : SET_FL;
	always_comb
	begin
		logic d;
		nxt_st = st_ff;
		nxt_cur = cur_ff;
		nxt_idx = idx_ff;
		nxt_ph = ph_ff;
		nxt_run = run_ff;
		nxt_sm = sm_ff;
		nxt_done = done_ff;
		nxt_f = f_ff;
		nxt_l = l_ff;
		nxt_cnt = cnt_ff;
		nxt_pre = pre_ff;
		nxt_dw = dw_ff;
		nxt_tc = (tc_ff != 8'h00) ? tc_ff - 8'h01 : 8'h00;
		d = at_end ? !up : up;
		case (st_ff)
			SQ_IDLE:
				if (trig)
				begin
					nxt_cur = first_f;
					nxt_idx = first_i;
					nxt_ph = 1'b0;
					nxt_done = 32'h0;
					nxt_run = 1'b1;
					nxt_sm = hwm & cfg_ff[CFG_STEP];
					nxt_st = SQ_SETTLE;
					nxt_cnt = set_cyc;
				end
			SQ_SETTLE:
			begin
				nxt_cnt = cnt_ff - 16'h0001;
				if (mode)
				begin
					nxt_f = swp ? cur_ff : mem[idx_ff][71:16];
					if (!swp) nxt_l = mem[idx_ff][15:0];
				end
				if (cnt_ff <= 16'h0001)
				begin
					// all setup finished: now the output trigger may fall
					if (cfg_ff[CFG_TOUT_EN] && (!cfg_ff[CFG_TOUT_LAST] || cyc_end))
						nxt_tc = 8'(TRIG_LOW_CYC);
					nxt_pre = DW_PRE;
					nxt_dw = dwell_ff;
					nxt_st = !run_ff ? SQ_IDLE : (sm_ff ? SQ_STEPW : SQ_DWELL);
				end
			end
			SQ_DWELL:
				if (pre_ff > 16'h0001) nxt_pre = pre_ff - 16'h0001;
				else if (dw_ff > 32'h1)
				begin
					nxt_pre = DW_PRE;
					nxt_dw = dw_ff - 32'h1;
				end
				else nxt_st = SQ_SETTLE;
			SQ_STEPW:
				if (trg_fall) nxt_st = SQ_SETTLE;
			default: nxt_st = SQ_IDLE;
		endcase
		// leaving a point: pick the next one
		if ((st_ff == SQ_DWELL || st_ff == SQ_STEPW) && nxt_st == SQ_SETTLE)
		begin
			nxt_cnt = set_cyc;
			if (cyc_end)
			begin
				nxt_done = done_ff + 32'h1;
				nxt_cur = first_f;
				nxt_idx = first_i;
				nxt_ph = 1'b0;
				if (cycles_ff != 32'h0 && nxt_done == cycles_ff)
				begin
					nxt_run = 1'b0;
					if (!cfg_ff[CFG_RET])
					begin
						nxt_cur = cur_ff;
						nxt_idx = idx_ff;
						nxt_st = SQ_IDLE;
					end
				end
			end
			else
			begin
				nxt_ph = ph_ff | at_end;
				nxt_cur = d ? cp[55:0] : cur_ff - fr_ff[FI_STEP];
				nxt_idx = d ? ip[9:0] : idx_ff - 10'h001;
			end
		end
		// stop trigger, soft trigger in step state, or single-tone mode
		if (st_ff != SQ_IDLE && run_ff && (!mode || (sm_ff ? soft_wr : trig)))
		begin
			nxt_run = 1'b0;
			nxt_st = SQ_IDLE;
			nxt_sm = 1'b0;
		end
		if (tone_wr)
		begin
			nxt_f = nxt_fr[FI_TONE];
			nxt_run = 1'b0;
			nxt_st = SQ_SETTLE;
			nxt_cnt = SET_F;
		end
		if (hr)
		begin
			nxt_st = SQ_IDLE;
			nxt_run = 1'b0;
			nxt_sm = 1'b0;
			nxt_f = TONE_RST;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_ff <= SQ_IDLE;
			{cur_ff, idx_ff, ph_ff, run_ff, sm_ff, done_ff} <= 101'h0;
			{l_ff, cnt_ff, pre_ff, dw_ff, tc_ff} <= 88'h0;
			f_ff <= TONE_RST;
		end
		else
		begin
			st_ff <= nxt_st;
			{cur_ff, idx_ff, ph_ff, run_ff, sm_ff, done_ff} <=
				{nxt_cur, nxt_idx, nxt_ph, nxt_run, nxt_sm, nxt_done};
			{l_ff, cnt_ff, pre_ff, dw_ff, tc_ff} <= {nxt_l, nxt_cnt, nxt_pre, nxt_dw, nxt_tc};
			f_ff <= nxt_f;
		end
	end

	// read mux and registered outputs
	logic [31:0] nxt_rd;
	always_comb
	begin
		nxt_rd = 32'h0;
		if (fr_hit) nxt_rd = i_wb_adr[2] ? {8'h00, fr_ff[fk][55:32]} : fr_ff[fk][31:0];
		else
			case (i_wb_adr)
				ADR_CTRL: nxt_rd = {30'h0, ctrl_ff};
				ADR_CFG: nxt_rd = {24'h0, cfg_ff};
				ADR_DWELL: nxt_rd = dwell_ff;
				ADR_CYCLES: nxt_rd = cycles_ff;
				ADR_POINTS: nxt_rd = {21'h0, pts_ff};
				ADR_BUF_LO: nxt_rd = blo_ff;
				ADR_BUF_LVL: nxt_rd = {16'h0, blvl_ff};
				ADR_STATUS: nxt_rd = {6'h0, idx_ff, 9'h0, ref_ff, xfer_ff, ph_ff, sm_ff, run_ff,
					st_ff};
				ADR_DONE: nxt_rd = done_ff;
				default: nxt_rd = 32'h0;
			endcase
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{ack_ff, o_wb_dat, o_nvm_addr, o_ref_ext_sel, o_busy, o_level} <= 61'h0;
			o_trigger_output_pin <= 1'b1;
			o_freq <= TONE_RST;
		end
		else
		begin
			ack_ff <= acc;
			o_wb_dat <= acc ? nxt_rd : 32'h0;
			o_trigger_output_pin <= nxt_tc == 8'h00;
			o_nvm_addr <= nxt_na;
			o_ref_ext_sel <= nxt_ref;
			o_busy <= nxt_st == SQ_SETTLE;
			o_freq <= nxt_f;
			o_level <= nxt_l;
		end
	end
	assign o_wb_ack = ack_ff;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_trig_single: assert property (trg_fall |=> !trg_fall) else $error("edge twice");
	a_tone_ignored: assert property (wr && fr_hit && fk == FI_TONE && mode && !hr
		|=> $stable(fr_ff[FI_TONE])) else $error("tone write taken");
	a_tone_retune: assert property (tone_wr && !hr |=> st_ff == SQ_SETTLE ##1
		o_freq == $past(fr_ff[FI_TONE])) else $error("no retune");
	a_trigger_output_pin_done: assert property ($fell(o_trigger_output_pin) |->
		$past(st_ff) == SQ_SETTLE && $past(cnt_ff) <= 16'h0001) else $error("early trig");
	a_stop_trig: assert property (trig && run_ff && !sm_ff && st_ff != SQ_IDLE && !tone_wr
		&& !hr |=> st_ff == SQ_IDLE && !run_ff) else $error("no stop");
	a_start_first: assert property (trig && st_ff == SQ_IDLE && !tone_wr && !hr
		|=> cur_ff == $past(first_f) && idx_ff == $past(first_i)) else $error("resumed");
	a_step_hold: assert property (st_ff == SQ_STEPW && mode && !trg_fall && !soft_wr
		&& !tone_wr && !hr |=> st_ff == SQ_STEPW) else $error("stepped w/o edge");
	a_tone_exit: assert property ((st_ff == SQ_DWELL || st_ff == SQ_STEPW) && !mode
		|=> st_ff == SQ_IDLE) else $error("still running");
	a_hard_reset: assert property (hr |=> cfg_ff == CFG_RST && ctrl_ff == CTRL_RST
		&& pts_ff == 11'h000) else $error("settings kept");
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
	c_step_wait: cover property (st_ff == SQ_STEPW ##[1:1000] st_ff == SQ_SETTLE);
	c_tri_return: cover property (ph_ff && st_ff == SQ_DWELL);
	c_cycles_end: cover property ($fell(run_ff) && st_ff != SQ_IDLE);
	c_trig_out: cover property ($fell(o_trigger_output_pin));
endmodule : sls_sweep_list_sequencer
`default_nettype wire
